// ### core/pebk_pkg.sv
// Constants, field layout and carrier types for the protection event bank.
// Assumes one 200 MHz clock and a serial front end that hands over
// decoded register reads and writes one byte at a time.
//
// Contract
// RULE1 - Event flags stay set until host writes one.
// RULE2 - Bit 4 self-test drives alarm line active.
// RULE3 - Bit 5 set on internal consistency failure.
// RULE4 - Host resets device on bit 5; persistent means fatal.
// RULE5 - Bit 3 set on every power-on reset.
// RULE6 - Reset loads defaults, copies OTP, raises power flag.
// RULE7 - Bit 2 set when received packet fails CRC.
// RULE8 - Bit 1 set when any cell undervoltage.
// RULE9 - Bit 0 set when any cell overvoltage.
// RULE10 - Overvoltage register bits 5..0 map cells 6..1.
// RULE11 - Undervoltage register bits 5..0 map cells 6..1.
// RULE12 - Parity register holds eight protected register results.
// RULE13 - Persistent condition sets flag again next evaluation.
// RULE14 - Alarm active while any flag or self-test set.
package pebk_pkg;

   // Register byte addresses as seen by the serial front end.
   localparam logic [7:0] ADDR_EVENT  = 8'h21; // Summary event flags.
   localparam logic [7:0] ADDR_OVER   = 8'h22; // Per-cell overvoltage.
   localparam logic [7:0] ADDR_UNDER  = 8'h23; // Per-cell undervoltage.
   localparam logic [7:0] ADDR_PARITY = 8'h24; // Parity of first eight.

   // Field positions in the summary event register.
   localparam int BIT_OVER   = 0; // Cell overvoltage summary.
   localparam int BIT_UNDER  = 1; // Cell undervoltage summary.
   localparam int BIT_CRC    = 2; // Packet CRC error.
   localparam int BIT_POR    = 3; // Power-on reset seen.
   localparam int BIT_FORCE  = 4; // Alarm self-test.
   localparam int BIT_IFAULT = 5; // Internal consistency failure.

   // Widths and counts.
   localparam int NUM_FLAGS = 6; // Summary bits 5..0.
   localparam int NUM_CELLS = 6; // Monitored cells.
   localparam int NUM_PROT  = 8; // Protected registers checked here.

   // Write-one-to-clear bits; the self-test bit is excluded.
   localparam logic [5:0] CLEAR_MASK = 6'h2F;

   // Reset values.
   localparam logic [7:0] RST_BYTE  = 8'h00; // Every register field.
   localparam logic [5:0] RST_FLAGS = 6'h00; // Sticky flag banks.

   // Evaluation period of the protection comparators.
   localparam int CLK_PERIOD_NS  = 5;
   localparam int EVAL_PERIOD_NS = 1000;
   localparam int EVAL_CYC =
      (EVAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // One register access from the serial front end.
   typedef struct packed {
      logic [7:0] addr;  // Register address.
      logic       wr;    // Write strobe, one cycle.
      logic       rd;    // Read strobe, one cycle.
      logic [7:0] wdata; // Write data.
   } pebk_req_type;

   // Power-on load sequencer, one-hot.
   typedef enum logic [2:0] {
      S_LOAD = 3'h1,
      S_WAIT = 3'h2,
      S_DONE = 3'h4
   } pebk_state_type;

endpackage

// ### core/pebk_sync.sv
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level whose bits need no mutual coherence.
module pebk_sync
   import pebk_pkg::*;
#(
   parameter int W = 6 // Number of bits.
) (
   input  wire logic         clk,   // System clock.
   input  wire logic         rst_n, // Asynchronous reset, active low.
   input  wire logic [W-1:0] din,   // Asynchronous levels.
   output logic      [W-1:0] dout   // Synchronised levels.
);

   logic [W-1:0] meta_r; // First stage, read only by the second stage.

   // Two stages; the first settles before anything looks at it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule // pebk_sync

// ### core/pebk_sticky.sv
// Bank of sticky flags with write-one-to-clear and set priority.
// Assumes set and clear are single-cycle pulses on the same clock.
module pebk_sticky
   import pebk_pkg::*;
#(
   parameter int W = 6 // Number of flags.
) (
   input  wire logic         clk,   // System clock.
   input  wire logic         rst_n, // Asynchronous reset, active low.
   input  wire logic [W-1:0] set,   // Per-flag set pulses.
   input  wire logic [W-1:0] clr,   // Per-flag clear pulses.
   output logic      [W-1:0] q      // Flag state.
);

   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= (q & ~clr) | set; // RULE1
      end
   end

endmodule // pebk_sticky

// ### core/pebk_top.sv
// Protection event register bank: summary flags, per-cell flags,
// parity results and the alarm line.
// Assumes a serial front end on the same clock, comparator levels
// from the analog side and a one-cycle-latency OTP read port.
module pebk_top
   import pebk_pkg::*;
#(
   parameter int EVAL_CYCLES = EVAL_CYC // Comparator evaluation period.
) (
   input  wire logic                 clk,        // 200 MHz clock.
   input  wire logic                 rst_n,      // Power-on reset, low.
   input  wire pebk_req_type         req,        // Register access.
   output logic [7:0]                rdData,     // Read data, registered.
   input  wire logic                 crcErr,     // Bad packet pulse.
   input  wire logic                 checkFail,  // Consistency fail pulse.
   input  wire logic [NUM_CELLS-1:0] cellOverIn, // Overvoltage levels.
   input  wire logic [NUM_CELLS-1:0] cellUnderIn,// Undervoltage levels.
   output logic                      otpRd,      // OTP read strobe.
   output logic [2:0]                otpAddr,    // OTP word index.
   input  wire logic [7:0]           otpData,    // OTP byte, next cycle.
   input  wire logic                 otpPar,     // Stored parity bit.
   output logic [NUM_PROT*8-1:0]     protCfg,    // Protected copy.
   output logic                      initDone,   // Load finished.
   output logic                      faultAlarm  // Alarm line, high.
);

   localparam int InitBound = 30;  // Cycles allowed for the OTP copy.

   logic [NUM_CELLS-1:0] overSync;  // Synchronised overvoltage.
   logic [NUM_CELLS-1:0] underSync; // Synchronised undervoltage.
   logic [7:0]  evalCnt_r;          // Evaluation divider.
   logic        evalTick_r;         // One-cycle evaluation enable.
   logic [NUM_FLAGS-1:0] evtSet;    // Summary set pulses.
   logic [NUM_FLAGS-1:0] evtClr;    // Summary clear pulses.
   logic [NUM_FLAGS-1:0] evtFlags;  // Summary flag state.
   logic [NUM_CELLS-1:0] overCells; // Per-cell overvoltage flags.
   logic [NUM_CELLS-1:0] underCells;// Per-cell undervoltage flags.
   logic        force_r;            // Self-test bit.
   logic        wrEvent;            // Write to the summary register.
   logic [7:0][7:0] cfg_r;          // Protected configuration copy.
   logic [NUM_PROT-1:0] parity_r;   // Parity mismatch per register.
   logic        otpVld_r;           // OTP data valid this cycle.
   logic        porPulse_r;         // One cycle after the copy ends.
   pebk_state_type state_r;         // Load sequencer state.

   // Comparator levels cross in from the analog side.
   pebk_sync #(.W(NUM_CELLS)) u_syncOver (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (cellOverIn),
      .dout  (overSync)
   );

   pebk_sync #(.W(NUM_CELLS)) u_syncUnder (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (cellUnderIn),
      .dout  (underSync)
   );

   // Divider that paces comparator evaluation.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evalCnt_r  <= 8'h00;
         evalTick_r <= 1'b0;
      end else if (evalCnt_r == 8'(EVAL_CYCLES - 1)) begin
         evalCnt_r  <= 8'h00;
         evalTick_r <= 1'b1;
      end else begin
         evalCnt_r  <= evalCnt_r + 8'h01;
         evalTick_r <= 1'b0;
      end
   end

   // Decode of host writes to the summary register.
   assign wrEvent = req.wr && (req.addr == ADDR_EVENT);
   assign evtClr  = wrEvent ? (req.wdata[5:0] & CLEAR_MASK) : RST_FLAGS;

   // Event sources; a held condition sets again on each tick.
   always_comb begin
      evtSet             = RST_FLAGS;
      evtSet[BIT_OVER]   = evalTick_r && (|overSync);      // RULE9 RULE13
      evtSet[BIT_UNDER]  = evalTick_r && (|underSync);     // RULE8 RULE13
      evtSet[BIT_CRC]    = crcErr;                         // RULE7
      evtSet[BIT_POR]    = porPulse_r;                     // RULE5
      evtSet[BIT_IFAULT] = checkFail ||
                           (porPulse_r && (|parity_r));    // RULE3
   end

   // Summary flags, write-one-to-clear with set priority.
   pebk_sticky #(.W(NUM_FLAGS)) u_evt (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (evtSet),
      .clr   (evtClr),
      .q     (evtFlags)
   );

   // Per-cell overvoltage flags, cleared with their summary bit.
   pebk_sticky #(.W(NUM_CELLS)) u_over (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (evalTick_r ? overSync : RST_FLAGS),        // RULE10
      .clr   ({NUM_CELLS{evtClr[BIT_OVER]}}),
      .q     (overCells)
   );

   // Per-cell undervoltage flags, cleared with their summary bit.
   pebk_sticky #(.W(NUM_CELLS)) u_under (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (evalTick_r ? underSync : RST_FLAGS),       // RULE11
      .clr   ({NUM_CELLS{evtClr[BIT_UNDER]}}),
      .q     (underCells)
   );

   // Self-test bit is plain read/write.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         force_r <= 1'b0;
      end else if (wrEvent) begin
         force_r <= req.wdata[BIT_FORCE]; // RULE2
      end
   end

   // Power-on sequencer copies eight OTP bytes, then raises the flag.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= S_LOAD;
         otpRd      <= 1'b0;
         otpAddr    <= 3'h0;
         otpVld_r   <= 1'b0;
         porPulse_r <= 1'b0;
         initDone   <= 1'b0;
         cfg_r      <= '0;
         parity_r   <= RST_BYTE;
      end else begin
         otpVld_r   <= otpRd;
         otpRd      <= 1'b0;
         porPulse_r <= 1'b0;
         case (state_r)
            // Issue a read of the current word.
            S_LOAD: begin
               otpRd   <= 1'b1;
               state_r <= S_WAIT;
            end
            // Capture the word and its parity check.
            S_WAIT: begin
               if (otpVld_r) begin
                  cfg_r[otpAddr]    <= otpData;           // RULE6
                  parity_r[otpAddr] <= (^otpData) ^ otpPar; // RULE12
                  if (otpAddr == 3'h7) begin
                     state_r    <= S_DONE;
                     porPulse_r <= 1'b1;                  // RULE6
                     initDone   <= 1'b1;
                  end else begin
                     otpAddr <= otpAddr + 3'h1;
                     state_r <= S_LOAD;
                  end
               end
            end
            // Copy complete; stay here until the next reset.
            S_DONE: begin
               state_r <= S_DONE;
            end
            default: begin
               state_r <= S_LOAD;
            end
         endcase
      end
   end

   assign protCfg = cfg_r;

   // Registered read port; unmapped addresses return zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= RST_BYTE;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_EVENT:  rdData <= {2'b00, evtFlags[5],
                                    force_r, evtFlags[3:0]};
            ADDR_OVER:   rdData <= {2'b00, overCells};   // RULE10
            ADDR_UNDER:  rdData <= {2'b00, underCells};  // RULE11
            ADDR_PARITY: rdData <= parity_r;             // RULE12
            default:     rdData <= RST_BYTE;
         endcase
      end
   end

   // Alarm follows any flag or the self-test bit.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faultAlarm <= 1'b0;
      end else begin
         faultAlarm <= (|evtFlags) || force_r; // RULE14 RULE2
      end
   end

   // A clear with no set empties the flag.
   property p_w1c;
      @(posedge clk) disable iff (!rst_n)
      (wrEvent && req.wdata[BIT_CRC] && !crcErr) |=> !evtFlags[BIT_CRC];
   endproperty
   a_w1c: assert property (p_w1c) // RULE1
      else $error("CRC flag survived a clear.");

   // Writing the self-test bit reaches the alarm two cycles later.
   property p_force;
      @(posedge clk) disable iff (!rst_n)
      (wrEvent && req.wdata[BIT_FORCE]) |=> ##1 faultAlarm;
   endproperty
   a_force: assert property (p_force) // RULE2
      else $error("Self-test did not raise the alarm.");

   // A parity mismatch at end of load raises the internal fault.
   property p_ifault;
      @(posedge clk) disable iff (!rst_n)
      (porPulse_r && (|parity_r)) |=> evtFlags[BIT_IFAULT];
   endproperty
   a_ifault: assert property (p_ifault) // RULE3
      else $error("Internal fault not raised on parity mismatch.");

   // The power flag follows the end of the copy.
   property p_por;
      @(posedge clk) disable iff (!rst_n)
      $rose(initDone) |=> ##1 evtFlags[BIT_POR];
   endproperty
   a_por: assert property (p_por) // RULE5
      else $error("Power flag missing after load.");

   // The copy finishes in bounded time.
   property p_init;
      @(posedge clk) disable iff (!rst_n)
      !initDone |-> ##[0:InitBound] initDone;
   endproperty
   a_init: assert property (p_init) // RULE6
      else $error("OTP copy took too long.");

   // A CRC pulse sets its flag.
   property p_crc;
      @(posedge clk) disable iff (!rst_n)
      crcErr |=> evtFlags[BIT_CRC];
   endproperty
   a_crc: assert property (p_crc) // RULE7
      else $error("CRC flag not set.");

   // Undervoltage at a tick sets the summary and the cell bits.
   property p_under;
      @(posedge clk) disable iff (!rst_n)
      (evalTick_r && (|underSync)) |=> evtFlags[BIT_UNDER] &&
         ((underCells & $past(underSync)) == $past(underSync));
   endproperty
   a_under: assert property (p_under) // RULE8 RULE11
      else $error("Undervoltage not latched.");

   // Overvoltage at a tick sets the summary and the cell bits.
   property p_over;
      @(posedge clk) disable iff (!rst_n)
      (evalTick_r && (|overSync)) |=> evtFlags[BIT_OVER] &&
         ((overCells & $past(overSync)) == $past(overSync));
   endproperty
   a_over: assert property (p_over) // RULE9 RULE10
      else $error("Overvoltage not latched.");

   // Parity register reads back the stored results.
   property p_parRd;
      @(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == ADDR_PARITY) |=> rdData == $past(parity_r);
   endproperty
   a_parRd: assert property (p_parRd) // RULE12
      else $error("Parity readback wrong.");

   // A cleared overvoltage flag comes back at the next live tick.
   property p_persist;
      @(posedge clk) disable iff (!rst_n)
      (!evtFlags[BIT_OVER] && evalTick_r && (|overSync))
         |=> evtFlags[BIT_OVER];
   endproperty
   a_persist: assert property (p_persist) // RULE13
      else $error("Persistent overvoltage stayed cleared.");

   // Alarm tracks the flags one cycle later.
   property p_alarm;
      @(posedge clk) disable iff (!rst_n)
      ##1 faultAlarm == ((|$past(evtFlags)) || $past(force_r));
   endproperty
   a_alarm: assert property (p_alarm) // RULE14
      else $error("Alarm does not match flags.");

   c_load: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(initDone));
   c_clear: cover property (@(posedge clk) disable iff (!rst_n)
      evtFlags[BIT_POR] ##1 !evtFlags[BIT_POR]);
   c_overRd: cover property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == ADDR_OVER && (|overCells));
   c_force: cover property (@(posedge clk) disable iff (!rst_n)
      force_r && !(|evtFlags));

endmodule // pebk_top

// ### test/pebk_host_model.sv
// Host-side model of the register port of the protection event bank.
// Assumes the bench calls its tasks and that requests launch at an edge.
module pebk_host_model
   import pebk_pkg::*;
(
   input  wire logic       clk,    // System clock.
   output pebk_req_type    req,    // Register request to the bank.
   input  wire logic [7:0] rdData  // Registered read data.
);
   timeunit 1ns;
   timeprecision 100ps;

   // The bus starts idle so no stray strobe is seen after reset.
   initial begin
      req = '0;
   end

   // One-cycle write strobe, released at the edge that samples it.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask

   // One-cycle read strobe; the data is taken once that edge has landed.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      d = rdData;
   endtask
endmodule // pebk_host_model

// ### test/testbench.sv
// Self-checking bench for the protection event bank.
// Assumes the host model file and the design files are compiled first.
module testbench
   import pebk_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int EVN = 8; // Short evaluation period for the run.

   logic                 clk;         // Bench clock.
   logic                 rst_n;       // Power-on reset, active low.
   pebk_req_type         req;         // Request from the host model.
   logic [7:0]           rdData;      // Read data.
   logic                 crcErr;      // Packet error pulse.
   logic                 checkFail;   // Consistency failure pulse.
   logic [NUM_CELLS-1:0] cellOverIn;  // Overvoltage levels.
   logic [NUM_CELLS-1:0] cellUnderIn; // Undervoltage levels.
   logic                 otpRd;       // OTP read strobe.
   logic [2:0]           otpAddr;     // OTP word index.
   logic [7:0]           otpData;     // OTP byte.
   logic                 otpPar;      // OTP parity bit.
   logic [NUM_PROT*8-1:0] protCfg;    // Protected copy.
   logic                 initDone;    // Load finished.
   logic                 faultAlarm;  // Alarm line.
   int                   badWord;     // OTP word given bad parity.
   int                   nErrors;     // Mismatches seen.
   int                   cmpCount;    // Comparisons made.
   logic [7:0]           rd;          // Scratch read value.

   // A register operation with the read value and alarm expected after it.
   typedef struct packed {
      logic       wr;    // Write when set, read otherwise.
      logic [7:0] addr;  // Register address.
      logic [7:0] data;  // Write data or expected read data.
      logic       alarm; // Expected alarm line afterwards.
   } pebk_row_type;

   pebk_row_type rows [13] = '{
      '{1'b0, 8'h21, 8'h08, 1'b1},
      '{1'b0, 8'h24, 8'h00, 1'b1},
      '{1'b0, 8'h22, 8'h00, 1'b1},
      '{1'b0, 8'h23, 8'h00, 1'b1},
      '{1'b1, 8'h21, 8'h08, 1'b0},
      '{1'b0, 8'h21, 8'h00, 1'b0},
      '{1'b1, 8'h21, 8'h10, 1'b1},
      '{1'b0, 8'h21, 8'h10, 1'b1},
      '{1'b1, 8'h22, 8'hFF, 1'b1},
      '{1'b0, 8'h22, 8'h00, 1'b1},
      '{1'b0, 8'h55, 8'h00, 1'b1},
      '{1'b1, 8'h21, 8'h00, 1'b0},
      '{1'b0, 8'h21, 8'h00, 1'b0}
   };

   // The design under test, with a short evaluation period.
   pebk_top #(.EVAL_CYCLES(EVN)) pebk_top_inst (
      .clk(clk), .rst_n(rst_n), .req(req), .rdData(rdData),
      .crcErr(crcErr), .checkFail(checkFail), .cellOverIn(cellOverIn),
      .cellUnderIn(cellUnderIn), .otpRd(otpRd), .otpAddr(otpAddr),
      .otpData(otpData), .otpPar(otpPar), .protCfg(protCfg),
      .initDone(initDone), .faultAlarm(faultAlarm)
   );

   // The host that reads and writes the registers.
   pebk_host_model pebk_host_model_inst (
      .clk(clk), .req(req), .rdData(rdData)
   );

   // Contents of the one-time store, distinct per word.
   function automatic logic [7:0] otpWord(input int k);
      return 8'hA0 + 8'(k);
   endfunction

   // OTP responder: valid only in the cycle after a strobe, else toggling.
   always @(posedge clk) begin
      if (otpRd) begin
         otpData <= otpWord(int'(otpAddr));
         otpPar  <= ^otpWord(int'(otpAddr)) ^ (int'(otpAddr) == badWord);
      end else begin
         otpData <= ~otpData;
         otpPar  <= ~otpPar;
      end
   end

   // The clock toggles every half period of 5 ns.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts one comparison and reports a mismatch.
   task automatic check(input string nm, input logic [63:0] e,
                        input logic [63:0] g);
      cmpCount++;
      if (g !== e) begin
         nErrors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // Reads a register and compares it with the expected byte.
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      pebk_host_model_inst.rd_reg(a, rd);
      check($sformatf("register %0h", a), e, rd);
   endtask

   // Lets a few evaluation periods pass.
   task automatic settle();
      repeat (2 * EVN + 4) @(posedge clk);
   endtask

   // Power-on reset held three cycles, then the protected copy is checked.
   task automatic boot(input int bad);
      badWord = bad;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("rdData in reset", 0, rdData);
      check("alarm in reset", 0, faultAlarm);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (initDone === 1'b1) break;
      end
      check("initDone", 1, initDone);
      for (int k = 0; k < NUM_PROT; k++) begin
         check("protCfg", otpWord(k), protCfg[8*k +: 8]);
      end
      repeat (4) @(posedge clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence: boot, table rows, then events, cells and reboots.
   initial begin
      rst_n = 1'b0;
      crcErr = 1'b0;
      checkFail = 1'b0;
      cellOverIn = '0;
      cellUnderIn = '0;
      otpData = 8'h5A;
      otpPar = 1'b0;
      badWord = -1;
      nErrors = 0;
      cmpCount = 0;
      boot(-1);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            pebk_host_model_inst.wr_reg(rows[i].addr, rows[i].data);
         end else begin
            rdchk(rows[i].addr, rows[i].data);
         end
         repeat (2) @(posedge clk);
         #1 check("faultAlarm", rows[i].alarm, faultAlarm);
      end
      // Each pulse latches its flag, which the host then clears.
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         crcErr <= (i == 0);
         checkFail <= (i == 1);
         @(posedge clk);
         crcErr <= 1'b0;
         checkFail <= 1'b0;
         rdchk(ADDR_EVENT, (i == 0) ? 8'h04 : 8'h20);
         check("alarm on event", 1, faultAlarm);
         pebk_host_model_inst.wr_reg(ADDR_EVENT, 8'h24);
         rdchk(ADDR_EVENT, 8'h00);
      end
      // Cell faults set summary and per-cell bits; a live fault returns.
      @(posedge clk);
      cellOverIn <= 6'h21;
      cellUnderIn <= 6'h12;
      settle();
      rdchk(ADDR_EVENT, 8'h03);
      rdchk(ADDR_OVER, 8'h21);
      rdchk(ADDR_UNDER, 8'h12);
      pebk_host_model_inst.wr_reg(ADDR_EVENT, 8'h03);
      settle();
      rdchk(ADDR_EVENT, 8'h03);
      @(posedge clk);
      cellOverIn <= '0;
      cellUnderIn <= '0;
      settle();
      pebk_host_model_inst.wr_reg(ADDR_EVENT, 8'h03);
      settle();
      rdchk(ADDR_EVENT, 8'h00);
      rdchk(ADDR_OVER, 8'h00);
      rdchk(ADDR_UNDER, 8'h00);
      #1 check("alarm released", 0, faultAlarm);
      // Bad parity on one word shows in its result bit and the fault flag.
      boot(2);
      rdchk(ADDR_PARITY, 8'h04);
      rdchk(ADDR_EVENT, 8'h28);
      // The host answers the fault with a reset, which clears it.
      boot(-1);
      rdchk(ADDR_EVENT, 8'h08);
      rdchk(ADDR_PARITY, 8'h00);
      tally_and_finish();
   end

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      repeat (5000) @(posedge clk);
      nErrors++;
      tally_and_finish();
   end
endmodule // testbench
